//--- rtl/rsm_pkg.sv
// Package of constants and carrier types for the reset strap pin mux
package rsm_pkg;
    localparam int ADDR_W = 24;
    localparam logic [23:0] INT_RAM_BASE = 24'h000000;
    localparam logic [23:0] INT_RSVD_BASE = 24'h008000;
    localparam logic [23:0] CS0_BASE = 24'h010000;
    localparam logic [23:0] CS1_BASE = 24'h400000;
    localparam logic [23:0] CS2_BASE = 24'h800000;
    localparam logic [23:0] CS3_BASE = 24'hc00000;
    localparam logic [23:0] ROM_BASE = 24'hff8000;
    localparam logic MODE_RST = 1'h0;
    localparam logic [2:0] BOOT_RST = 3'h0;
    localparam logic ROM_DIS_RST = 1'h0;
    localparam logic [2:0] BOOT_DIRECT16 = 3'h0;
    localparam int PIO_W = 36;
    localparam int PIO_ADDR_LO = 0;
    localparam int PIO_DATA_LO = 4;
    localparam int PIO_CTRL_LO = 20;
    localparam int CTRL_READY_IN = 3;
    localparam int CTRL_HOLD_IN = 14;

    typedef enum {
        BOOT_DIRECT_16, BOOT_SERIAL_EPROM, BOOT_SERIAL_PORT, BOOT_EXT_MEM16,
        BOOT_DIRECT_32, BOOT_HOST_PORT, BOOT_TWO_WIRE_EPROM, BOOT_UART
    } rsm_boot_t;

    typedef enum {
        REG_INT_RAM, REG_INT_RSVD, REG_ROM, REG_CS0, REG_CS1, REG_CS2, REG_CS3
    } rsm_region_t;

    // Parallel pin group: address 21..2, data 31..0, control 15..0
    typedef struct packed {
        logic [19:0] addr;
        logic [31:0] data;
        logic [15:0] ctrl;
    } rsm_pins_t;
endpackage

//--- rtl/rsm_strap_latch.sv
// Strap capture register taken at the release of reset
`timescale 1ns/10ps
module rsm_strap_latch (
    input wire logic clk, // Core clock
    input wire logic rst_b, // Async reset, active low
    input wire logic modeStrap, // Mux mode strap level
    input wire logic [2:0] bootStrap, // Boot select strap levels
    output logic modeSel, // Latched mux mode
    output logic [2:0] bootSel, // Latched boot mode
    output logic captured // Capture done
);
    logic done_ff, nxt_done;
    logic mode_ff, nxt_mode;
    logic [2:0] boot_ff, nxt_boot;

    always_comb begin
        nxt_done = 1'b1;
        nxt_mode = mode_ff;
        nxt_boot = boot_ff;
        // Async reset may not load a port, so catch on first edge after release
        if (!done_ff) begin
            nxt_mode = modeStrap;
            nxt_boot = bootStrap;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            done_ff <= 1'b0;
            mode_ff <= rsm_pkg::MODE_RST;
            boot_ff <= rsm_pkg::BOOT_RST;
        end else begin
            done_ff <= nxt_done;
            mode_ff <= nxt_mode;
            boot_ff <= nxt_boot;
        end
    end

    assign modeSel = mode_ff;
    assign bootSel = boot_ff;
    assign captured = done_ff;
endmodule

//--- rtl/rsm_pin_mux.sv
// Reset strap driven parallel pin mux, boot decode and address decode
//
// Notes on behaviour
// - Mux mode comes only from the strap level captured at reset.
// - Strap low: memory interface and host port off; A17..2, D15..0 unused.
// - General-purpose mode gives 16 control, 4 address, 16 data pins to I/O.
// - I/O bits: A21..18 to 3..0, D31..16 to 19..4, C0..15 to 20..35.
// - Strap high: memory interface address 21..2 and data 31..0 drive pins.
// - Control pins carry strobes, chip and byte enables, hold in that order.
// - Select register mode bit: 0 general-purpose, 1 memory interface.
// - Strap high enables host port multiplexed over eight shared data pins.
// - Select register keeps showing the strap-chosen configuration after reset.
// - Three boot straps latched at reset release; shared with I/O bits 2..0.
// - Boot codes decode to the eight documented boot methods.
// - Lowest 64K of space 0 internal; external space 0 starts at 010000h.
// - ROM disable bit 0 maps FF8000h upward to on-chip ROM.
// - Spaces 1, 2, 3 start at 400000h, 800000h, C00000h.
// - Memory interface clock gated off when not selected.
`timescale 1ns/10ps
module rsm_pin_mux (
    input wire logic clk, // Core clock, 50 MHz
    input wire logic rst_b, // Async reset, active low
    input wire logic mux_mode_strap_pin, // Mux mode strap level
    input wire logic [2:0] boot_select_straps, // Boot strap levels
    input wire logic romDisWrEn, // Software write strobe for ROM disable
    input wire logic romDisWrData, // Software write value for ROM disable
    input wire rsm_pkg::rsm_pins_t memIfOut, // Memory interface output levels
    input wire rsm_pkg::rsm_pins_t memIfOe, // Memory interface output enables
    input wire logic [7:0] hostOut, // Host port shared data out
    input wire logic [7:0] hostOe, // Host port shared data enables
    input wire logic [35:0] pioOut, // Parallel I/O output levels
    input wire logic [35:0] pioOe, // Parallel I/O output enables
    input wire rsm_pkg::rsm_pins_t pinIn, // Parallel pin input levels
    input wire logic [7:0] hostPinIn, // Host shared data pin levels
    input wire logic [23:0] busAddr, // Byte address to decode
    output rsm_pkg::rsm_pins_t pinOut, // Parallel pin output levels
    output rsm_pkg::rsm_pins_t pinOe, // Parallel pin output enables
    output logic [7:0] host_shared_data_pins_out, // Host data pin levels
    output logic [7:0] host_shared_data_pins_oe, // Host data pin enables
    output rsm_pkg::rsm_pins_t memIfIn, // Pin levels seen by memory interface
    output logic [7:0] hostIn, // Pin levels seen by host port
    output logic [35:0] pioIn, // Pin levels seen by parallel I/O
    output logic external_bus_select_reg, // Mux mode bit of select register
    output logic memIfEn, // Memory interface enabled
    output logic hostEn, // Host port enabled, multiplexed
    output logic memIfClkEn, // Memory interface clock enable
    output logic [2:0] bootMode, // Latched boot straps
    output rsm_pkg::rsm_boot_t bootKind, // Decoded boot method
    output logic rom_disable_bit, // ROM disable status bit
    output rsm_pkg::rsm_region_t region, // Decoded region of busAddr
    output logic regionExt // Decoded region is external
);
    // ********************************
    // Strap capture
    // ********************************
    logic modeSel, capDone;
    logic [2:0] bootSel;

    rsm_strap_latch u_latch (
        .clk(clk),
        .rst_b(rst_b),
        .modeStrap(mux_mode_strap_pin),
        .bootStrap(boot_select_straps),
        .modeSel(modeSel),
        .bootSel(bootSel),
        .captured(capDone)
    );

    // ********************************
    // Decode functions
    // ********************************
    function automatic rsm_pkg::rsm_boot_t boot_decode(input logic [2:0] code);
        rsm_pkg::rsm_boot_t k;
        case (code)
            3'h0: k = rsm_pkg::BOOT_DIRECT_16;
            3'h1: k = rsm_pkg::BOOT_SERIAL_EPROM;
            3'h2: k = rsm_pkg::BOOT_SERIAL_PORT;
            3'h3: k = rsm_pkg::BOOT_EXT_MEM16;
            3'h4: k = rsm_pkg::BOOT_DIRECT_32;
            3'h5: k = rsm_pkg::BOOT_HOST_PORT;
            3'h6: k = rsm_pkg::BOOT_TWO_WIRE_EPROM;
            default: k = rsm_pkg::BOOT_UART;
        endcase
        return k;
    endfunction

    function automatic rsm_pkg::rsm_region_t addr_decode(input logic [23:0] a,
                                                        input logic romOff);
        rsm_pkg::rsm_region_t r;
        // ROM takes top of space 3
        if (!romOff && a >= rsm_pkg::ROM_BASE) begin
            r = rsm_pkg::REG_ROM;
        end else if (a >= rsm_pkg::CS3_BASE) begin
            r = rsm_pkg::REG_CS3;
        end else if (a >= rsm_pkg::CS2_BASE) begin
            r = rsm_pkg::REG_CS2;
        end else if (a >= rsm_pkg::CS1_BASE) begin
            r = rsm_pkg::REG_CS1;
        end else if (a >= rsm_pkg::CS0_BASE) begin
            r = rsm_pkg::REG_CS0;
        end else if (a >= rsm_pkg::INT_RSVD_BASE) begin
            r = rsm_pkg::REG_INT_RSVD;
        end else begin
            r = rsm_pkg::REG_INT_RAM;
        end
        return r;
    endfunction

    // ********************************
    // Registered state and outputs
    // ********************************
    logic romDis_ff, nxt_romDis;
    logic modeReg_ff, nxt_modeReg;
    rsm_pkg::rsm_pins_t pinOut_ff, nxt_pinOut, pinOe_ff, nxt_pinOe, memIn_ff, nxt_memIn;
    logic [7:0] hOut_ff, nxt_hOut, hOe_ff, nxt_hOe, hIn_ff, nxt_hIn;
    logic [35:0] pioIn_ff, nxt_pioIn;
    logic memEn_ff, nxt_memEn, hostEn_ff, nxt_hostEn, clkEn_ff, nxt_clkEn;
    logic [2:0] boot_ff, nxt_boot;
    rsm_pkg::rsm_boot_t kind_ff, nxt_kind;
    rsm_pkg::rsm_region_t reg_ff, nxt_reg;
    logic ext_ff, nxt_ext;

    always_comb begin
        nxt_modeReg = modeSel;
        nxt_boot = bootSel;
        nxt_kind = boot_decode(bootSel);
        nxt_romDis = romDis_ff;
        // ROM disable set from straps once; software may rewrite later
        if (!capDone) begin
            nxt_romDis = (boot_select_straps == rsm_pkg::BOOT_DIRECT16);
        end else if (romDisWrEn) begin
            nxt_romDis = romDisWrData;
        end
        nxt_memEn = capDone & modeSel;
        nxt_hostEn = capDone & modeSel;
        nxt_clkEn = capDone & modeSel;
        nxt_reg = addr_decode(busAddr, romDis_ff);
        nxt_ext = !(nxt_reg == rsm_pkg::REG_INT_RAM || nxt_reg == rsm_pkg::REG_INT_RSVD
                    || nxt_reg == rsm_pkg::REG_ROM);
        nxt_pinOut = '0;
        nxt_pinOe = '0;
        nxt_memIn = '0;
        nxt_pioIn = '0;
        nxt_hOut = '0;
        nxt_hOe = '0;
        nxt_hIn = '0;
        if (!capDone) begin
            // Pins stay undriven until the strap is known
            nxt_pinOe = '0;
        end else if (modeSel) begin
            nxt_pinOut = memIfOut;
            nxt_pinOe = memIfOe;
            nxt_memIn = pinIn;
            nxt_hOut = hostOut;
            nxt_hOe = hostOe;
            nxt_hIn = hostPinIn;
        end else begin
            nxt_pinOut.addr[19:16] = pioOut[3:0];
            nxt_pinOe.addr[19:16] = pioOe[3:0];
            nxt_pinOut.data[31:16] = pioOut[19:4];
            nxt_pinOe.data[31:16] = pioOe[19:4];
            nxt_pinOut.ctrl = pioOut[35:20];
            nxt_pinOe.ctrl = pioOe[35:20];
            nxt_pioIn = {pinIn.ctrl, pinIn.data[31:16], pinIn.addr[19:16]};
            nxt_pinOe.addr[15:0] = '0;
            nxt_pinOe.data[15:0] = '0;
        end
        // Ready and hold request are inputs in memory interface mode; never drive them there
        nxt_pinOe.ctrl[rsm_pkg::CTRL_READY_IN] = !modeSel & nxt_pinOe.ctrl[rsm_pkg::CTRL_READY_IN];
        nxt_pinOe.ctrl[rsm_pkg::CTRL_HOLD_IN] = !modeSel & nxt_pinOe.ctrl[rsm_pkg::CTRL_HOLD_IN];
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            romDis_ff <= rsm_pkg::ROM_DIS_RST;
            modeReg_ff <= rsm_pkg::MODE_RST;
            pinOut_ff <= '0;
            pinOe_ff <= '0;
            memIn_ff <= '0;
            hOut_ff <= 8'h00;
            hOe_ff <= 8'h00;
            hIn_ff <= 8'h00;
            pioIn_ff <= 36'h0;
            memEn_ff <= 1'b0;
            hostEn_ff <= 1'b0;
            clkEn_ff <= 1'b0;
            boot_ff <= rsm_pkg::BOOT_RST;
            kind_ff <= rsm_pkg::BOOT_DIRECT_16;
            reg_ff <= rsm_pkg::REG_INT_RAM;
            ext_ff <= 1'b0;
        end else begin
            romDis_ff <= nxt_romDis;
            modeReg_ff <= nxt_modeReg;
            pinOut_ff <= nxt_pinOut;
            pinOe_ff <= nxt_pinOe;
            memIn_ff <= nxt_memIn;
            hOut_ff <= nxt_hOut;
            hOe_ff <= nxt_hOe;
            hIn_ff <= nxt_hIn;
            pioIn_ff <= nxt_pioIn;
            memEn_ff <= nxt_memEn;
            hostEn_ff <= nxt_hostEn;
            clkEn_ff <= nxt_clkEn;
            boot_ff <= nxt_boot;
            kind_ff <= nxt_kind;
            reg_ff <= nxt_reg;
            ext_ff <= nxt_ext;
        end
    end

    assign pinOut = pinOut_ff;
    assign pinOe = pinOe_ff;
    assign memIfIn = memIn_ff;
    assign host_shared_data_pins_out = hOut_ff;
    assign host_shared_data_pins_oe = hOe_ff;
    assign hostIn = hIn_ff;
    assign pioIn = pioIn_ff;
    assign external_bus_select_reg = modeReg_ff;
    assign memIfEn = memEn_ff;
    assign hostEn = hostEn_ff;
    assign memIfClkEn = clkEn_ff;
    assign bootMode = boot_ff;
    assign bootKind = kind_ff;
    assign rom_disable_bit = romDis_ff;
    assign region = reg_ff;
    assign regionExt = ext_ff;
endmodule

//--- tb/rsm_pin_mux_props.sv
// Checker for the reset strap pin mux
`timescale 1ns/10ps
module rsm_pin_mux_props (
    input wire logic clk, // Core clock
    input wire logic rst_b, // Async reset
    input wire logic mux_mode_strap_pin, // Mode strap
    input wire logic [2:0] boot_select_straps, // Boot straps
    input wire logic [35:0] pioOut, // I/O levels
    input wire rsm_pkg::rsm_pins_t memIfOut, // Memory levels
    input wire logic [23:0] busAddr, // Decode address
    input wire rsm_pkg::rsm_pins_t pinOut, // Pin levels
    input wire rsm_pkg::rsm_pins_t pinOe, // Pin enables
    input wire logic external_bus_select_reg, // Mode bit
    input wire logic memIfEn, // Memory enable
    input wire logic hostEn, // Host enable
    input wire logic memIfClkEn, // Memory clock enable
    input wire logic [2:0] bootMode, // Boot code
    input var rsm_pkg::rsm_boot_t bootKind, // Boot method
    input wire logic rom_disable_bit, // ROM disable
    input var rsm_pkg::rsm_region_t region // Region
);
    // ****************************************
    // Helper state
    // ****************************************
    logic [1:0] edgeCnt_ff;
    logic [1:0] nxt_edgeCnt;
    logic modeQ_ff;
    logic [2:0] bootQ_ff;
    logic [35:0] pioQ_ff;
    rsm_pkg::rsm_pins_t memQ_ff;
    logic [23:0] addrQ_ff;
    wire rdy = edgeCnt_ff == 2'h3;
    always_comb begin
        nxt_edgeCnt = rdy ? edgeCnt_ff : edgeCnt_ff + 2'h1;
    end
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            edgeCnt_ff <= 2'h0;
            modeQ_ff <= 1'h0;
            bootQ_ff <= 3'h0;
        end else begin
            edgeCnt_ff <= nxt_edgeCnt;
            modeQ_ff <= (edgeCnt_ff == 2'h0) ? mux_mode_strap_pin : modeQ_ff;
            bootQ_ff <= (edgeCnt_ff == 2'h0) ? boot_select_straps : bootQ_ff;
        end
    end
    always_ff @(posedge clk) begin
        pioQ_ff <= pioOut;
        memQ_ff <= memIfOut;
        addrQ_ff <= busAddr;
    end
    // ****************************************
    // Properties
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    wire io = !external_bus_select_reg;
    property p_mode; rdy |-> external_bus_select_reg == modeQ_ff && bootMode == bootQ_ff; endproperty
    a_mode: assert property (p_mode) else $error("mode or boot not from straps");
    property p_en; rdy |-> {memIfEn, hostEn, memIfClkEn} == {3{external_bus_select_reg}}; endproperty
    a_en: assert property (p_en) else $error("enables disagree with mode");
    property p_stab; rdy |=> $stable(external_bus_select_reg) && $stable(bootMode); endproperty
    a_stab: assert property (p_stab) else $error("mode changed after reset");
    property p_resv; rdy && io |-> pinOe.addr[15:0] == 16'h0 && pinOe.data[15:0] == 16'h0; endproperty
    a_resv: assert property (p_resv) else $error("reserved pin driven");
    property p_pio; rdy && io |-> pinOut.ctrl == pioQ_ff[35:20] && pinOut.addr[19:16] == pioQ_ff[3:0];
    endproperty
    a_pio: assert property (p_pio) else $error("io bit routing wrong");
    property p_mem; rdy && !io |-> pinOut == memQ_ff; endproperty
    a_mem: assert property (p_mem) else $error("memory routing wrong");
    property p_ctl; rdy && !io |-> pinOe.ctrl[3] == 1'h0 && pinOe.ctrl[14] == 1'h0; endproperty
    a_ctl: assert property (p_ctl) else $error("input control pin driven");
    property p_kind; rdy |-> bootKind == rsm_pkg::rsm_boot_t'(bootMode); endproperty
    a_kind: assert property (p_kind) else $error("boot decode wrong");
    property p_ram; rdy && addrQ_ff < 24'h008000 |-> region == rsm_pkg::REG_INT_RAM; endproperty
    a_ram: assert property (p_ram) else $error("internal ram decode wrong");
    property p_cs; rdy && addrQ_ff[23:22] == 2'h1 |-> region == rsm_pkg::REG_CS1; endproperty
    a_cs: assert property (p_cs) else $error("space 1 decode wrong");
    property p_rom; rdy && addrQ_ff >= 24'hff8000 && $stable(rom_disable_bit) |->
        region == (rom_disable_bit ? rsm_pkg::REG_CS3 : rsm_pkg::REG_ROM); endproperty
    a_rom: assert property (p_rom) else $error("rom decode wrong");
    c_mem: cover property (rdy && !io);
    c_io: cover property (rdy && io);
    c_rom: cover property (rdy && region == rsm_pkg::REG_ROM);
endmodule
bind rsm_pin_mux rsm_pin_mux_props u_props (.*);

//--- tb/rsm_board_model.sv
// Board logic on the shared parallel and host pins
`timescale 1ns/10ps
module rsm_board_model (
    input wire rsm_pkg::rsm_pins_t pinOut, // Device pin levels
    input wire rsm_pkg::rsm_pins_t pinOe, // Device pin enables
    input wire logic [7:0] hostOut, // Device host levels
    input wire logic [7:0] hostOe, // Device host enables
    input wire rsm_pkg::rsm_pins_t extVal, // Board drive levels
    output rsm_pkg::rsm_pins_t pinIn, // Resolved pin levels
    output logic [7:0] hostPinIn // Resolved host levels
);
    // Board drives only where the device has released the pin
    assign pinIn = (pinOut & pinOe) | (extVal & ~pinOe);
    assign hostPinIn = (hostOut & hostOe) | (~hostOut & ~hostOe);
endmodule

//--- tb/rsm_pin_mux_bench.sv
// Testbench for the reset strap pin mux
`timescale 1ns/10ps
module rsm_pin_mux_bench;
    logic clk = 1'h0;
    logic rst_b = 1'h0;
    logic strap = 1'h0;
    logic [2:0] boot = 3'h0;
    logic romWr = 1'h0;
    logic romDat = 1'h0;
    rsm_pkg::rsm_pins_t memOut = 68'h1_2345_6789_abcd_ef01;
    rsm_pkg::rsm_pins_t memOe = '1;
    rsm_pkg::rsm_pins_t ext = 68'ha_5a5a_c3c3_3c3c_9696;
    logic [7:0] hOut = 8'h5a;
    logic [35:0] pOut = 36'h9a5c31e7b;
    logic [35:0] pOe = '1;
    logic [23:0] addr = 24'h0;
    rsm_pkg::rsm_pins_t pinIn, pinOut, pinOe, memIn;
    logic [7:0] hPinIn, hdOut, hdOe, hIn;
    logic [35:0] pIn;
    logic mode, memEn, hEn, clkEn, romBit, regExt;
    logic [2:0] bootMode;
    rsm_pkg::rsm_boot_t bootKind;
    rsm_pkg::rsm_region_t region;
    rsm_pkg::rsm_pins_t memExp;
    int num_errors = 0;
    int check_count = 0;
    logic [23:0] aTab [8] = '{24'h007fff, 24'h008000, 24'h00ffff, 24'h010000,
        24'h400000, 24'h800000, 24'hc00000, 24'hff8000};
    int rTab [8] = '{rsm_pkg::REG_INT_RAM, rsm_pkg::REG_INT_RSVD, rsm_pkg::REG_INT_RSVD,
        rsm_pkg::REG_CS0, rsm_pkg::REG_CS1, rsm_pkg::REG_CS2, rsm_pkg::REG_CS3, rsm_pkg::REG_ROM};

    rsm_pin_mux dut (.clk(clk), .rst_b(rst_b), .mux_mode_strap_pin(strap),
        .boot_select_straps(boot), .romDisWrEn(romWr), .romDisWrData(romDat),
        .memIfOut(memOut), .memIfOe(memOe), .hostOut(hOut), .hostOe(8'hff), .pioOut(pOut),
        .pioOe(pOe), .pinIn(pinIn), .hostPinIn(hPinIn), .busAddr(addr), .pinOut(pinOut),
        .pinOe(pinOe), .host_shared_data_pins_out(hdOut), .host_shared_data_pins_oe(hdOe),
        .memIfIn(memIn), .hostIn(hIn), .pioIn(pIn), .external_bus_select_reg(mode),
        .memIfEn(memEn), .hostEn(hEn), .memIfClkEn(clkEn), .bootMode(bootMode),
        .bootKind(bootKind), .rom_disable_bit(romBit), .region(region), .regionExt(regExt));
    rsm_board_model board (.pinOut(pinOut), .pinOe(pinOe), .hostOut(hdOut), .hostOe(hdOe),
        .extVal(ext), .pinIn(pinIn), .hostPinIn(hPinIn));

    initial begin
        forever #10 clk = ~clk;
    end

    task automatic chk(input logic [67:0] got, input logic [67:0] exp);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic end_sim();
        if (num_errors == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic boot_up(input logic s, input logic [2:0] b);
        @(negedge clk);
        rst_b = 1'h0;
        strap = s;
        boot = b;
        repeat (8) @(negedge clk);
        rst_b = 1'h1;
        repeat (3) @(negedge clk);
    endtask

    initial begin
        for (int i = 0; i < 8; i++) begin
            boot_up(i[0] ^ i[1], i[2:0]);
            chk(mode, i[0] ^ i[1]);
            chk({memEn, hEn, clkEn}, {3{i[0] ^ i[1]}});
            chk(bootMode, i[2:0]);
            chk(bootKind, i);
            chk(romBit, i == 0);
        end
        // Late strap change must not move the mux
        strap = 1'h1;
        repeat (2) @(negedge clk);
        chk(mode, 1'h0);
        chk({pinOut.ctrl, pinOut.data[31:16], pinOut.addr[19:16]}, pOut);
        chk({pinOe.addr[15:0], pinOe.data[15:0]}, 32'h0);
        chk({pinOe.addr[19:16], pinOe.data[31:16], pinOe.ctrl}, 36'hfffffffff);
        chk(memIn, 68'h0);
        chk(hdOe, 8'h00);
        chk(hIn, 8'h00);
        pOe = '0;
        repeat (2) @(negedge clk);
        chk(pIn, {ext.ctrl, ext.data[31:16], ext.addr[19:16]});
        boot_up(1'h1, 3'h5);
        chk(pinOut, memOut);
        chk({pinOe.ctrl[3], pinOe.ctrl[14], pinOe.addr}, 22'h0fffff);
        chk(hdOut, hOut);
        chk(hdOe, 8'hff);
        chk(hIn, hOut);
        // Ready and hold request come from the board side
        memExp = memOut;
        memExp.ctrl[3] = ext.ctrl[3];
        memExp.ctrl[14] = ext.ctrl[14];
        chk(memIn, memExp);
        chk(pIn, 36'h0);
        for (int i = 0; i < 8; i++) begin
            addr = aTab[i];
            @(negedge clk);
            chk(region, rTab[i]);
            chk(regExt, i >= 3 && i < 7);
        end
        // only the ROM bit is rewritten, never the mode
        romWr = 1'h1;
        romDat = 1'h1;
        @(negedge clk);
        romWr = 1'h0;
        repeat (2) @(negedge clk);
        chk(romBit, 1'h1);
        chk(region, rsm_pkg::REG_CS3);
        chk(regExt, 1'h1);
        chk(mode, 1'h1);
        end_sim();
    end
endmodule
